// *** hw/qpcd_pkg.sv ***
// Purpose: constants and types for the quad pot command decoder
// Assumes: sys_clk at 25 MHz, bus clock at most about 3.1 MHz
// Notes:   How it works list below
//
// How it works
// - command byte: 4-bit register select, 2-bit operation, two data bits (ninth used)
// - operation code decodes to write, read, increment by one, decrement by one
// - increment and decrement accepted only at wiper locations 00h, 01h, 06h, 07h
// - valid select and operation pair is acknowledged on the bus
// - invalid select and operation pair gets a not-acknowledge instead
// - after an invalid pair every command is ignored until a new start
// - write forms nine bits: ninth data bit (zero at 7-bit wipers) above the eight data-byte bits
// - only nine bits stored per location; tenth command-byte bit ignored
// - wiper top bit is ninth data bit on 8-bit parts, data bit 7 on 7-bit
// - nine-bit write lets an 8-bit wiper reach full scale at 100h or above
// - only write and read carry data bytes; increment and decrement are one byte
// - read returns two bytes holding the nine stored bits of the location
// - terminal-control and status locations reject increment and decrement
// - location 05h is read-only status image; write, increment, decrement invalid
// - start or stop in place of a data bit aborts without updating the location
// - continuous sequences: 18n+11 clocks for write or read, 9n+11 for step commands
// - high-voltage select pin at elevated level marks a command high-voltage
// - increment saturates at 100h on 8-bit parts, 80h on 7-bit parts
// - volatile writes commit in the acknowledge slot after each data byte
// - read uses last valid command location; pointer is 00h after reset
package qpcd_pkg;
  localparam logic [3:0] LOC_WIPER_ZERO  = 4'h0;
  localparam logic [3:0] LOC_WIPER_ONE   = 4'h1;
  localparam logic [3:0] LOC_TERM_ZERO   = 4'h4;
  localparam logic [3:0] LOC_STATUS      = 4'h5;
  localparam logic [3:0] LOC_WIPER_TWO   = 4'h6;
  localparam logic [3:0] LOC_WIPER_THREE = 4'h7;
  localparam logic [3:0] LOC_TERM_ONE    = 4'hA;
  localparam logic [3:0] POINTER_RESET   = 4'h0;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC   = 2'h1;
  localparam logic [1:0] OP_DEC   = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;

  // fixed upper address bits; low two come from pins
  localparam logic [4:0] DEV_ADDR_HIGH = 5'h0B;

  localparam logic [8:0] FULL_SCALE_8BIT = 9'h100;
  localparam logic [8:0] FULL_SCALE_7BIT = 9'h080;
  localparam logic [8:0] WIPER_RESET     = 9'h080;
  localparam logic [8:0] TERM_RESET      = 9'h1FF;
  localparam logic [8:0] STATUS_RESET    = 9'h000;
  localparam logic [8:0] ZERO_SCALE      = 9'h000;

  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [2:0] LAST_BIT   = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hC,
    ST_ERR       = 4'h8
  } qpcd_state_t;
endpackage : qpcd_pkg

// *** hw/qpcd_bus_if.sv ***
// Purpose: bus events passed from the line sampler to the decoder
// Assumes: all signals on sys_clk, one-cycle pulses except sdaLevel
// Notes:   none
`timescale 1ns/1ps
interface qpcd_bus_if;
  logic sclRise;
  logic sclFall;
  logic sdaLevel;
  logic startSeen;
  logic stopSeen;
  modport sampler (output sclRise, sclFall, sdaLevel, startSeen, stopSeen);
  modport decoder (input sclRise, sclFall, sdaLevel, startSeen, stopSeen);
endinterface : qpcd_bus_if

// *** hw/qpcd_line_sampler.sv ***
// Purpose: synchronise bus clock and data, find edges, start and stop
// Assumes: bus clock slower than sys_clk by at least eight
// Notes:   events lag the pins by about two sys_clk cycles
`timescale 1ns/1ps
module qpcd_line_sampler (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   reset,
  // bus pins
  input  wire logic   sclIn,
  input  wire logic   sdaIn,
  // events
  qpcd_bus_if.sampler bus
);
  // stage 0 feeds stage 1 only; edges look at stages 1 and 2
  logic [2:0] sclPipe;
  logic [2:0] sdaPipe;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclPipe <= 3'h7;
      sdaPipe <= 3'h7;
    end else begin
      sclPipe <= {sclPipe[1:0], sclIn};
      sdaPipe <= {sdaPipe[1:0], sdaIn};
    end
  end

  assign bus.sclRise   = sclPipe[1] & ~sclPipe[2];
  assign bus.sclFall   = ~sclPipe[1] & sclPipe[2];
  assign bus.sdaLevel  = sdaPipe[1];
  assign bus.startSeen = sclPipe[1] & sclPipe[2] & ~sdaPipe[1] & sdaPipe[2];
  assign bus.stopSeen  = sclPipe[1] & sclPipe[2] & sdaPipe[1] & ~sdaPipe[2];
endmodule : qpcd_line_sampler

// *** hw/qpcd_cmd_decoder.sv ***
// Purpose: two-wire target that decodes pot commands into wiper and control registers
// Assumes: controller keeps bus clock low for at least four sys_clk cycles
// Notes:   data pin is open drain; sdaOe high pulls the line to sdaOut (always low)
`timescale 1ns/1ps
module qpcd_cmd_decoder #(
  parameter int         WIPER_BITS   = 8,
  parameter logic [8:0] WIPER_INIT   = qpcd_pkg::WIPER_RESET,
  parameter logic [8:0] TERM_INIT    = qpcd_pkg::TERM_RESET,
  parameter logic [8:0] STATUS_IMAGE = qpcd_pkg::STATUS_RESET
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // bus pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // address straps; addrZeroPin shares its pin with high-voltage select
  input  wire logic       addrOnePin,
  input  wire logic       addrZeroPin,
  input  wire logic       elevatedLevel,
  // register contents
  output logic [8:0]      wiperZero,
  output logic [8:0]      wiperOne,
  output logic [8:0]      wiperTwo,
  output logic [8:0]      wiperThree,
  output logic [8:0]      terminalControlZero,
  output logic [8:0]      terminalControlOne,
  // status
  output logic            highVoltageCommand,
  output logic            commandError
);
  qpcd_bus_if bus ();

  qpcd_line_sampler u_sampler (
    .sys_clk (sys_clk),
    .reset   (reset),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .bus     (bus.sampler)
  );

  localparam logic [8:0] FULL_SCALE = (WIPER_BITS == 7) ? qpcd_pkg::FULL_SCALE_7BIT
                                                        : qpcd_pkg::FULL_SCALE_8BIT;

  qpcd_pkg::qpcd_state_t state;
  qpcd_pkg::qpcd_state_t next_state;

  logic [2:0] pinSyncA;
  logic [2:0] pinSyncB;
  logic [1:0] strapWait;
  logic       addrZeroLatched;
  logic [7:0] shiftReg;
  logic [2:0] bitCnt;
  logic       byteFull;
  logic [3:0] pointer;
  logic [1:0] curOp;
  logic       ninthBit;
  logic       readMode;
  logic       masterAck;
  logic       lowNext;
  logic [7:0] txShift;
  logic       next_sdaOe;
  logic [8:0] regFile [0:15];

  // pins from outside the clock domain: two flops each, stage A read only by B
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinSyncA <= 3'h0;
      pinSyncB <= 3'h0;
    end else begin
      pinSyncA <= {elevatedLevel, addrZeroPin, addrOnePin};
      pinSyncB <= pinSyncA;
    end
  end

  wire addrOneSync  = pinSyncB[0];
  wire addrZeroSync = pinSyncB[1];
  wire hvSync       = pinSyncB[2];

  // shared pin is caught once after release, before high-voltage use can move it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strapWait       <= 2'h0;
      addrZeroLatched <= 1'b0;
    end else if (strapWait < qpcd_pkg::STRAP_WAIT) begin
      strapWait <= strapWait + 2'h1;
    end else if (strapWait == qpcd_pkg::STRAP_WAIT && state == qpcd_pkg::ST_IDLE) begin
      addrZeroLatched <= addrZeroSync;
      strapWait       <= strapWait + 2'h1;
    end
  end

  // decode of the byte held in the shift register
  wire        rxState = (state == qpcd_pkg::ST_ADDR) || (state == qpcd_pkg::ST_CMD) ||
                        (state == qpcd_pkg::ST_WDATA);
  wire        ackState = (state == qpcd_pkg::ST_ADDR_ACK) || (state == qpcd_pkg::ST_CMD_ACK) ||
                         (state == qpcd_pkg::ST_WDATA_ACK);
  wire        byteEnd = bus.sclFall && byteFull;
  wire        addrHit = shiftReg[7:1] ==
                        {qpcd_pkg::DEV_ADDR_HIGH, addrOneSync, addrZeroLatched};
  wire [3:0]  selField = shiftReg[7:4];
  wire [1:0]  opField  = shiftReg[3:2];
  wire        ninthField = shiftReg[0];

  wire isWiper = (selField == qpcd_pkg::LOC_WIPER_ZERO) ||
                 (selField == qpcd_pkg::LOC_WIPER_ONE) ||
                 (selField == qpcd_pkg::LOC_WIPER_TWO) ||
                 (selField == qpcd_pkg::LOC_WIPER_THREE);
  wire isTerm  = (selField == qpcd_pkg::LOC_TERM_ZERO) ||
                 (selField == qpcd_pkg::LOC_TERM_ONE);
  wire isStatus = (selField == qpcd_pkg::LOC_STATUS);
  wire stepOp  = (opField == qpcd_pkg::OP_INC) || (opField == qpcd_pkg::OP_DEC);
  wire cmdValid = (stepOp && isWiper) ||
                  (opField == qpcd_pkg::OP_WRITE && (isWiper || isTerm)) ||
                  (opField == qpcd_pkg::OP_READ && (isWiper || isTerm || isStatus));

  // write value built from the saved ninth bit and the data byte
  wire        pointWiper = (pointer == qpcd_pkg::LOC_WIPER_ZERO) ||
                           (pointer == qpcd_pkg::LOC_WIPER_ONE) ||
                           (pointer == qpcd_pkg::LOC_WIPER_TWO) ||
                           (pointer == qpcd_pkg::LOC_WIPER_THREE);
  wire        sevenBitTop = (WIPER_BITS == 7) && pointWiper;
  wire [8:0]  writeValue = sevenBitTop ? {1'b0, shiftReg}
                                       : {ninthBit, shiftReg};
  wire [8:0]  curValue = regFile[pointer];
  wire [8:0]  incValue = (curValue >= FULL_SCALE) ? curValue
                                                  : curValue + 9'h001;
  wire [8:0]  decValue = (curValue == qpcd_pkg::ZERO_SCALE) ? curValue
                                                            : curValue - 9'h001;
  wire [7:0]  readHigh = {6'h00, 1'b0, curValue[8]};
  wire [7:0]  readLow  = curValue[7:0];
  wire [7:0]  loadByte = lowNext ? readLow : readHigh;

  // commit strobes fall on the rising clock of the acknowledge slot
  wire ackRise    = bus.sclRise && ackState && !bus.startSeen && !bus.stopSeen;
  wire dataCommit = ackRise && (state == qpcd_pkg::ST_WDATA_ACK);
  wire stepCommit = ackRise && (state == qpcd_pkg::ST_CMD_ACK) &&
                    (curOp == qpcd_pkg::OP_INC || curOp == qpcd_pkg::OP_DEC);
  wire cmdTaken   = byteEnd && state == qpcd_pkg::ST_CMD && cmdValid;

  // state sequencing and data line drive
  always_comb begin
    next_state = state;
    next_sdaOe = sdaOe;
    if (bus.startSeen) begin
      next_state = qpcd_pkg::ST_ADDR;
      next_sdaOe = 1'b0;
    end else if (bus.stopSeen) begin
      next_state = (state == qpcd_pkg::ST_ERR) ? qpcd_pkg::ST_ERR
                                               : qpcd_pkg::ST_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      case (state)
        qpcd_pkg::ST_ADDR: begin
          if (byteEnd) begin
            next_state = addrHit ? qpcd_pkg::ST_ADDR_ACK : qpcd_pkg::ST_IDLE;
            next_sdaOe = addrHit;
          end
        end
        qpcd_pkg::ST_CMD: begin
          if (byteEnd) begin
            next_state = cmdValid ? qpcd_pkg::ST_CMD_ACK : qpcd_pkg::ST_ERR;
            next_sdaOe = cmdValid;
          end
        end
        qpcd_pkg::ST_WDATA: begin
          if (byteEnd) begin
            next_state = qpcd_pkg::ST_WDATA_ACK;
            next_sdaOe = 1'b1;
          end
        end
        qpcd_pkg::ST_ADDR_ACK: begin
          if (bus.sclFall) begin
            next_state = readMode ? qpcd_pkg::ST_RDATA : qpcd_pkg::ST_CMD;
            next_sdaOe = readMode && !loadByte[7];
          end
        end
        qpcd_pkg::ST_CMD_ACK: begin
          if (bus.sclFall) begin
            next_state = (curOp == qpcd_pkg::OP_WRITE) ? qpcd_pkg::ST_WDATA
                                                       : qpcd_pkg::ST_CMD;
            next_sdaOe = 1'b0;
          end
        end
        qpcd_pkg::ST_WDATA_ACK: begin
          if (bus.sclFall) begin
            next_state = qpcd_pkg::ST_CMD;
            next_sdaOe = 1'b0;
          end
        end
        qpcd_pkg::ST_RDATA: begin
          if (byteEnd) begin
            next_state = qpcd_pkg::ST_RACK;
            next_sdaOe = 1'b0;
          end else if (bus.sclFall) begin
            next_sdaOe = !txShift[6];
          end
        end
        qpcd_pkg::ST_RACK: begin
          if (bus.sclFall) begin
            next_state = masterAck ? qpcd_pkg::ST_RDATA : qpcd_pkg::ST_IDLE;
            next_sdaOe = masterAck && !loadByte[7];
          end
        end
        qpcd_pkg::ST_ERR: begin
          next_sdaOe = 1'b0;
        end
        default: begin
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state  <= qpcd_pkg::ST_IDLE;
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      state  <= next_state;
      sdaOe  <= next_sdaOe;
      sdaOut <= 1'b0;
    end
  end

  // bit counter and receive shifter; abort by start or stop restarts the count
  always_ff @(posedge sys_clk) begin
    if (reset || bus.startSeen || bus.stopSeen) begin
      bitCnt   <= 3'h0;
      byteFull <= 1'b0;
      shiftReg <= 8'h00;
    end else if (bus.sclRise && (rxState || state == qpcd_pkg::ST_RDATA)) begin
      bitCnt   <= bitCnt + 3'h1;
      byteFull <= (bitCnt == qpcd_pkg::LAST_BIT);
      if (rxState) begin
        shiftReg <= {shiftReg[6:0], bus.sdaLevel};
      end
    end else if (bus.sclFall) begin
      byteFull <= 1'b0;
    end
  end

  // transmit shifter loaded as the data line is first driven
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txShift <= 8'h00;
      lowNext <= 1'b0;
    end else if (bus.startSeen) begin
      lowNext <= 1'b0;
    end else if (bus.sclFall && next_state == qpcd_pkg::ST_RDATA &&
                 state != qpcd_pkg::ST_RDATA) begin
      txShift <= loadByte;
      lowNext <= !lowNext;
    end else if (bus.sclFall && state == qpcd_pkg::ST_RDATA) begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  // transfer direction, controller acknowledge and command fields
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readMode  <= 1'b0;
      masterAck <= 1'b0;
      curOp     <= qpcd_pkg::OP_WRITE;
      ninthBit  <= 1'b0;
    end else begin
      if (byteEnd && state == qpcd_pkg::ST_ADDR) begin
        readMode <= shiftReg[0];
      end
      if (bus.sclRise && state == qpcd_pkg::ST_RACK) begin
        masterAck <= !bus.sdaLevel;
      end
      if (cmdTaken) begin
        curOp    <= opField;
        ninthBit <= ninthField;
      end
    end
  end

  // pointer survives stop and repeated start
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pointer <= qpcd_pkg::POINTER_RESET;
    end else if (cmdTaken) begin
      pointer <= selField;
    end
  end

  // command flags: high-voltage state and rejection seen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      highVoltageCommand <= 1'b0;
      commandError       <= 1'b0;
    end else begin
      if (byteEnd && state == qpcd_pkg::ST_CMD) begin
        highVoltageCommand <= hvSync;
      end
      if (byteEnd && state == qpcd_pkg::ST_CMD && !cmdValid) begin
        commandError <= 1'b1;
      end else if (bus.startSeen) begin
        commandError <= 1'b0;
      end
    end
  end

  // location storage; status image is never written
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        regFile[i] <= qpcd_pkg::ZERO_SCALE;
      end
      regFile[qpcd_pkg::LOC_WIPER_ZERO]  <= WIPER_INIT;
      regFile[qpcd_pkg::LOC_WIPER_ONE]   <= WIPER_INIT;
      regFile[qpcd_pkg::LOC_WIPER_TWO]   <= WIPER_INIT;
      regFile[qpcd_pkg::LOC_WIPER_THREE] <= WIPER_INIT;
      regFile[qpcd_pkg::LOC_TERM_ZERO]   <= TERM_INIT;
      regFile[qpcd_pkg::LOC_TERM_ONE]    <= TERM_INIT;
      regFile[qpcd_pkg::LOC_STATUS]      <= STATUS_IMAGE;
    end else if (dataCommit) begin
      regFile[pointer] <= writeValue;
    end else if (stepCommit) begin
      regFile[pointer] <= (curOp == qpcd_pkg::OP_INC) ? incValue : decValue;
    end
  end

  assign wiperZero           = regFile[qpcd_pkg::LOC_WIPER_ZERO];
  assign wiperOne            = regFile[qpcd_pkg::LOC_WIPER_ONE];
  assign wiperTwo            = regFile[qpcd_pkg::LOC_WIPER_TWO];
  assign wiperThree          = regFile[qpcd_pkg::LOC_WIPER_THREE];
  assign terminalControlZero = regFile[qpcd_pkg::LOC_TERM_ZERO];
  assign terminalControlOne  = regFile[qpcd_pkg::LOC_TERM_ONE];
endmodule : qpcd_cmd_decoder

// *** dv/qpcd_bus_model.sv ***
// Purpose: behavioural bus controller facing the pot command decoder
// Assumes: bus clock period 320 ns, data line pulled up
// Notes:   the bench calls these tasks by hierarchical name
`timescale 1ns/1ps
module qpcd_bus_model (
  // clock
  input  wire logic sys_clk,
  // bus lines
  output logic      sclLine,
  output logic      sdaDrive,
  input  wire logic sdaWire
);
  initial sclLine = 1'b1;
  initial sdaDrive = 1'b1;
  // moves land on sys_clk edges: 5 cycles low, 3 high; read on a falling edge mid-high
  task automatic xfer_bit(input logic b, output logic r);
    repeat (2) @(posedge sys_clk);
    sdaDrive <= b;
    repeat (3) @(posedge sys_clk);
    sclLine <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    r = sdaWire;
    repeat (2) @(posedge sys_clk);
    sclLine <= 1'b0;
  endtask : xfer_bit
  // also the only way out of a rejected command
  task automatic start_cond();
    repeat (2) @(posedge sys_clk);
    sdaDrive <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sclLine <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sdaDrive <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sclLine <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    repeat (2) @(posedge sys_clk);
    sdaDrive <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sclLine <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sdaDrive <= 1'b1;
  endtask : stop_cond
  // whole bytes only, msb first, then the answer slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte
  // nak high ends a read
  task automatic recv_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
    xfer_bit(nak, r);
  endtask : recv_byte
endmodule : qpcd_bus_model

// *** dv/qpcd_cmd_decoder_checker.sv ***
// Purpose: bus-side assertions for the pot command decoder
// Assumes: one sys_clk domain, synchronous reset
// Notes:   sees top ports only; bound after the module
`timescale 1ns/1ps
module qpcd_cmd_decoder_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // bus pins
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       elevatedLevel,
  // register contents
  input wire logic [8:0] wiperZero,
  input wire logic [8:0] wiperOne,
  input wire logic [8:0] wiperTwo,
  input wire logic [8:0] wiperThree,
  input wire logic [8:0] terminalControlZero,
  input wire logic [8:0] terminalControlOne,
  // status
  input wire logic       highVoltageCommand,
  input wire logic       commandError
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  wire [53:0] regs = {wiperZero, wiperOne, wiperTwo, wiperThree,
                      terminalControlZero, terminalControlOne};
  sequence s_drive_hold; sdaOe [*6]; endsequence
  sequence s_line_quiet; !sdaOe [*8]; endsequence
  property p_drive_low; sdaOe |-> sdaOut == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("data driven high");
  property p_ack_stands; $rose(sdaOe) |-> s_drive_hold; endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("drive too short");
  // a moving data line while the clock is high would read as start or stop
  property p_moves_low; $changed(sdaOe) |-> !$past(sclIn, 2); endproperty
  a_moves_low: assert property (p_moves_low) else $error("data moved in clock high");
  property p_release; sdaOe |-> ##[1:100] !sdaOe; endproperty
  a_release: assert property (p_release) else $error("line never released");
  property p_err_quiet; commandError |-> !sdaOe; endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("drive in error state");
  property p_err_nack; $rose(commandError) |-> s_line_quiet; endproperty
  a_err_nack: assert property (p_err_nack) else $error("rejected byte answered");
  property p_err_frozen; commandError |=> $stable(regs); endproperty
  a_err_frozen: assert property (p_err_frozen) else $error("register moved in error");
  property p_hv_follow;
    $changed(highVoltageCommand) |-> highVoltageCommand == elevatedLevel;
  endproperty
  a_hv_follow: assert property (p_hv_follow) else $error("hv flag wrong");
endmodule : qpcd_cmd_decoder_checker
bind qpcd_cmd_decoder qpcd_cmd_decoder_checker chk_u (
  .sys_clk(sys_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .elevatedLevel(elevatedLevel), .wiperZero(wiperZero), .wiperOne(wiperOne),
  .wiperTwo(wiperTwo), .wiperThree(wiperThree),
  .terminalControlZero(terminalControlZero), .terminalControlOne(terminalControlOne),
  .highVoltageCommand(highVoltageCommand), .commandError(commandError));

// *** dv/test_quad_pot_cmd_decoder.sv ***
// Purpose: self-checking bench for the pot command decoder
// Assumes: bus model tasks, 320 ns bus clock, pulled-up data line
// Notes:   straps tied low, so the write address byte is 58h
`timescale 1ns/1ps
module test_quad_pot_cmd_decoder;
  localparam int LIMIT = 20000;
  logic       sys_clk, reset, addrOnePin, addrZeroPin, elevatedLevel;
  logic       sdaOut, sdaOe, hvCmd, cmdErr, sclLine, sdaDrive, bitIn;
  logic [8:0] wv [4];
  logic [8:0] tv [2];
  logic [3:0] wLoc [4] = '{4'h0, 4'h1, 4'h6, 4'h7};
  logic [7:0] bad [6] = '{8'h44, 8'hA8, 8'h50, 8'h58, 8'h24, 8'hFC};
  int         fails, samplesChecked, cycles;
  wire        sdaWire = sdaDrive & ~sdaOe;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  qpcd_cmd_decoder dut_u (
    .sys_clk(sys_clk), .reset(reset), .sclIn(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrOnePin(addrOnePin), .addrZeroPin(addrZeroPin),
    .elevatedLevel(elevatedLevel), .wiperZero(wv[0]), .wiperOne(wv[1]),
    .wiperTwo(wv[2]), .wiperThree(wv[3]), .terminalControlZero(tv[0]),
    .terminalControlOne(tv[1]), .highVoltageCommand(hvCmd), .commandError(cmdErr));
  qpcd_bus_model ctl_u (.sys_clk(sys_clk), .sclLine(sclLine), .sdaDrive(sdaDrive),
    .sdaWire(sdaWire));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] b, input logic expAck);
    logic ack;
    ctl_u.send_byte(b, ack);
    check("ack", {8'h00, ack}, {8'h00, expAck});
  endtask : cmd
  task automatic open_wr();
    ctl_u.start_cond();
    cmd(8'h58, 1'b1);
  endtask : open_wr
  // high byte carries only the ninth bit; tenth reads back zero
  task automatic rd(input logic [8:0] exp);
    logic [7:0] hi, lo;
    ctl_u.start_cond();
    cmd(8'h59, 1'b1);
    ctl_u.recv_byte(1'b0, hi);
    ctl_u.recv_byte(1'b1, lo);
    ctl_u.stop_cond();
    check("readHigh", {1'b0, hi}, {8'h00, exp[8]});
    check("readLow", {1'b0, lo}, {1'b0, exp[7:0]});
  endtask : rd
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    reset = 1'b1;
    addrOnePin = 1'b0;
    addrZeroPin = 1'b0;
    elevatedLevel = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #13;
    foreach (wv[i]) check("wiperReset", wv[i], qpcd_pkg::WIPER_RESET);
    foreach (tv[i]) check("termReset", tv[i], qpcd_pkg::TERM_RESET);
    rd(9'h080);
    $display("reset test done");
    open_wr();
    cmd(8'h03, 1'b1);
    cmd(8'hA5, 1'b1);
    cmd(8'h41, 1'b1);
    cmd(8'h23, 1'b1);
    cmd(8'hA0, 1'b1);
    cmd(8'h3C, 1'b1);
    ctl_u.stop_cond();
    check("wiperZero", wv[0], 9'h1A5);
    check("termOne", tv[1], 9'h03C);
    check("termZero", tv[0], 9'h123);
    rd(9'h03C);
    $display("write test done");
    open_wr();
    foreach (wLoc[i]) begin
      cmd({wLoc[i], qpcd_pkg::OP_WRITE, 2'b00}, 1'b1);
      cmd(8'hFF, 1'b1);
      repeat (2) cmd({wLoc[i], qpcd_pkg::OP_INC, 2'b00}, 1'b1);
    end
    ctl_u.stop_cond();
    foreach (wv[i]) check("incSat", wv[i], qpcd_pkg::FULL_SCALE_8BIT);
    open_wr();
    foreach (wLoc[i]) begin
      cmd({wLoc[i], qpcd_pkg::OP_WRITE, 2'b00}, 1'b1);
      cmd(8'h01, 1'b1);
      repeat (2) cmd({wLoc[i], qpcd_pkg::OP_DEC, 2'b00}, 1'b1);
    end
    ctl_u.stop_cond();
    foreach (wv[i]) check("decFloor", wv[i], qpcd_pkg::ZERO_SCALE);
    $display("step test done");
    foreach (bad[i]) begin
      open_wr();
      cmd(bad[i], 1'b0);
      check("cmdErr", {8'h00, cmdErr}, 9'h001);
      cmd(8'h10, 1'b0);
      cmd(8'h55, 1'b0);
      ctl_u.stop_cond();
      check("errHeld", {8'h00, cmdErr}, 9'h001);
      check("wiperOne", wv[1], 9'h000);
    end
    open_wr();
    check("errClear", {8'h00, cmdErr}, 9'h000);
    cmd(8'h5C, 1'b1);
    rd(qpcd_pkg::STATUS_RESET);
    $display("error test done");
    open_wr();
    cmd(8'h70, 1'b1);
    repeat (4) ctl_u.xfer_bit(1'b1, bitIn);
    ctl_u.stop_cond();
    check("abort", wv[3], 9'h000);
    @(posedge sys_clk) elevatedLevel <= 1'b1;
    #13;
    open_wr();
    cmd(8'h74, 1'b1);
    ctl_u.stop_cond();
    check("hvFlag", {8'h00, hvCmd}, 9'h001);
    check("hvInc", wv[3], 9'h001);
    $display("abort and high-voltage test done");
    finish_test();
  end
endmodule : test_quad_pot_cmd_decoder
